//--- program_ram_ecc_pkg.sv
/*
  Package for the program-RAM ECC block: register offsets, field positions,
  reset values, Hamming geometry and the packed carriers for the array ports.
  Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
package program_ram_ecc_pkg;
  localparam int DATA_W  = 48;
  localparam int CHECK_W = 7;
  localparam int ADDR_W  = 16;

  // register byte offsets
  localparam logic [7:0] OFF_FLAGS   = 8'h00;
  localparam logic [7:0] OFF_INTERRUPT_ENABLE_REG_ZERO    = 8'h04;
  localparam logic [7:0] OFF_STAT_LO = 8'h08;
  localparam logic [7:0] OFF_STAT_HI = 8'h0C;
  localparam logic [7:0] OFF_TRAPS   = 8'h10;
  localparam logic [7:0] OFF_TGT     = 8'h14;
  localparam logic [7:0] OFF_FCTL_HI = 8'h18;
  localparam logic [7:0] OFF_FCTL_LO = 8'h1C;
  localparam logic [7:0] OFF_KEY     = 8'h20;
  localparam logic [7:0] OFF_TRAPCTL = 8'h24;

  // field positions
  localparam int SBE_BIT      = 13;
  localparam int DBE_BIT      = 1;
  localparam int ARM_BIT      = 0;
  localparam int HANDLER_BIT  = 0;
  localparam int DED_OUT_BIT  = 8;
  localparam int DED_IN_BIT   = 9;

  localparam logic [7:0] KEY_FIRST   = 8'h55;
  localparam logic [7:0] KEY_SECOND  = 8'hAA;
  localparam logic [7:0] PTR_NONE    = 8'hFF;
  localparam logic [15:0] FCTL_HI_RST = 16'hFFFF;
  localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

  typedef struct packed {
    logic [ADDR_W-1:0]  addr;
    logic               we;
    logic [DATA_W-1:0]  data;
    logic [CHECK_W-1:0] check;
  } array_req_t;

  typedef struct packed {
    logic [DATA_W-1:0]  data;
    logic [CHECK_W-1:0] check;
  } array_word_t;

  typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} key_state_t;
endpackage : program_ram_ecc_pkg

//--- program_ram_ecc.sv
/*
  Program-RAM ECC controller with fault injection and AHB-Lite registers.
  Assumes a core-side port for fetch/table access (one-cycle request, answer
  one cycle after the array answers) and an array that answers in the cycle of its request.
*/
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module program_ram_ecc
  import program_ram_ecc_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                nrst,
  // ahb-lite slave
  input  wire logic                hsel,
  input  wire logic [7:0]          haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  // core side
  input  wire logic                core_req,
  input  wire logic                core_we,
  input  wire logic [ADDR_W-1:0]   core_addr,
  input  wire logic [DATA_W-1:0]   core_wdata,
  output logic                     core_rvalid,
  output logic [DATA_W-1:0]        core_rdata,
  // array side
  output array_req_t               array_req,
  output logic                     array_req_valid,
  input  wire array_word_t         array_rdata,
  // system
  output logic                     irq,
  output logic                     hard_trap,
  output logic                     device_reset
);

  // hamming code: positions 1..54, powers of two hold check bits, bit 0
  // of position space unused; check[6] is overall parity for detection
  function automatic logic [5:0] data_pos(input int i);
    int p;
    int k;
    p = 0;
    k = -1;
    for (int q = 1; q < 64; q++) begin
      if ((q & (q - 1)) != 0 && k < i) begin
        k = k + 1;
        p = q;
      end
    end
    return p[5:0];
  endfunction : data_pos

  function automatic logic [CHECK_W-1:0] ecc_gen(input logic [DATA_W-1:0] d);
    logic [5:0] s;
    logic [5:0] pos;
    s = 6'h00;
    for (int i = 0; i < DATA_W; i++) begin
      pos = data_pos(i);
      if (d[i]) s = s ^ pos;
    end
    return {^d ^ ^s, s};
  endfunction : ecc_gen

  // bus address phase capture
  logic       ph_wr;
  logic       ph_rd;
  logic [7:0] ph_addr;
  wire        ap_valid = hsel & hready & htrans[1];

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ph_wr   <= 1'b0;
      ph_rd   <= 1'b0;
      ph_addr <= 8'h00;
    end else begin
      ph_wr   <= ap_valid & hwrite;
      ph_rd   <= ap_valid & ~hwrite;
      ph_addr <= haddr;
    end
  end

  wire wr_flags = ph_wr && ph_addr == OFF_FLAGS;
  wire wr_interrupt_enable_reg_zero  = ph_wr && ph_addr == OFF_INTERRUPT_ENABLE_REG_ZERO;
  wire wr_traps = ph_wr && ph_addr == OFF_TRAPS;
  wire wr_tgt   = ph_wr && ph_addr == OFF_TGT;
  wire wr_fhi   = ph_wr && ph_addr == OFF_FCTL_HI;
  wire wr_flo   = ph_wr && ph_addr == OFF_FCTL_LO;
  wire wr_key   = ph_wr && ph_addr == OFF_KEY;
  wire wr_trc   = ph_wr && ph_addr == OFF_TRAPCTL;

  // control registers
  logic               sbe_flag;
  logic               sbe_ie;
  logic               dbe_flag;
  logic [ADDR_W-1:0]  target;
  logic [7:0]         ptr1;
  logic [7:0]         ptr2;
  logic               arm;
  logic               handler;
  key_state_t         key_st;
  logic [7:0]         sec_out;
  logic [7:0]         sec_in;
  logic [7:0]         synd;
  logic               ded_out;
  logic               ded_in;

  // unlock: 0x55 then 0xAA with no other bus write between
  key_state_t next_key_st;
  always_comb begin
    next_key_st = key_st;
    if (wr_key && hwdata[7:0] == KEY_FIRST)
      next_key_st = KEY_HALF;
    else if (wr_key && key_st == KEY_HALF && hwdata[7:0] == KEY_SECOND)
      next_key_st = KEY_OPEN;
    else if (ph_wr && !(wr_flo && key_st == KEY_OPEN))
      next_key_st = KEY_IDLE;
    else if (wr_flo)
      next_key_st = KEY_IDLE;
  end

  // core access pipeline; read data returns two cycles after request
  wire              tgt_hit  = core_req && core_addr == target;
  wire              inj_now  = arm && tgt_hit;
  wire [DATA_W-1:0] mask1    = (ptr1 < 8'(DATA_W)) ?
                               (48'h1 << ptr1[5:0]) : 48'h0;
  wire [DATA_W-1:0] mask2    = (ptr2 != PTR_NONE && ptr2 < 8'(DATA_W)) ?
                               (48'h1 << ptr2[5:0]) : 48'h0;
  wire [DATA_W-1:0] inj_mask = mask1 ^ mask2;

  wire [DATA_W-1:0] wr_data  = core_wdata ^ (inj_now ? inj_mask : 48'h0);

  logic              rd_pend;
  logic              rd_inj;
  logic [DATA_W-1:0] rd_mask;

  // check bits are computed on true data so the injected flip is an error
  wire [CHECK_W-1:0] wr_check = ecc_gen(core_wdata);

  wire [DATA_W-1:0] fetched  = array_rdata.data ^
                               (rd_inj ? rd_mask : 48'h0);
  wire [CHECK_W-1:0] recomp  = ecc_gen(fetched);
  wire [5:0] syn6  = recomp[5:0] ^ array_rdata.check[5:0];
  wire       par   = ^fetched ^ ^array_rdata.check;
  wire       sbe   = rd_pend && par; // odd overall parity: single error
  wire       dbe   = rd_pend && !par && syn6 != 6'h00;

  // map syndrome position back to data index, check-bit hits need no fix
  logic [DATA_W-1:0] fix;
  logic [7:0]        bitpos;
  always_comb begin
    fix    = 48'h0;
    bitpos = 8'h00;
    for (int i = 0; i < DATA_W; i++) begin
      if (data_pos(i) == syn6) begin
        fix[i] = 1'b1;
        bitpos = 8'(i + 1);
      end
    end
  end

  wire [DATA_W-1:0] corrected = sbe ? (fetched ^ fix) : fetched;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_pend <= 1'b0;
      rd_inj  <= 1'b0;
      rd_mask <= 48'h0;
    end else begin
      rd_pend <= core_req & ~core_we;
      rd_inj  <= inj_now & ~core_we;
      rd_mask <= inj_mask;
    end
  end

  // array request and core answer
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      array_req       <= '0;
      array_req_valid <= 1'b0;
      core_rvalid     <= 1'b0;
      core_rdata      <= 48'h0;
    end else begin
      array_req_valid <= core_req;
      array_req.addr  <= core_addr;
      array_req.we    <= core_we;
      array_req.data  <= wr_data;
      array_req.check <= wr_check;
      core_rvalid     <= rd_pend;
      core_rdata      <= dbe ? fetched : corrected;
    end
  end

  // status, flags and injection control
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sbe_flag <= 1'b0;
      sbe_ie   <= 1'b0;
      dbe_flag <= 1'b0;
      target   <= '0;
      ptr1     <= FCTL_HI_RST[7:0];
      ptr2     <= FCTL_HI_RST[15:8];
      arm      <= 1'b0;
      handler  <= 1'b0;
      key_st   <= KEY_IDLE;
      sec_out  <= 8'h00;
      sec_in   <= 8'h00;
      synd     <= 8'h00;
      ded_out  <= 1'b0;
      ded_in   <= 1'b0;
    end else begin
      key_st <= next_key_st;
      // hardware set wins over a software clear in the same cycle
      sbe_flag <= sbe | (sbe_flag & ~(wr_flags & ~hwdata[SBE_BIT]));
      dbe_flag <= dbe | (dbe_flag & ~(wr_traps & ~hwdata[DBE_BIT]));
      if (wr_interrupt_enable_reg_zero) sbe_ie <= hwdata[SBE_BIT];
      if (wr_trc) handler <= hwdata[HANDLER_BIT];
      if (wr_tgt) target <= hwdata[ADDR_W-1:0];
      if (wr_fhi) begin
        ptr1 <= hwdata[7:0];
        ptr2 <= hwdata[15:8];
      end
      // arm only takes when unlocked; one injection then disarms
      if (wr_flo && key_st == KEY_OPEN)
        arm <= hwdata[ARM_BIT];
      else if (wr_flo && !hwdata[ARM_BIT])
        arm <= 1'b0;
      else if (inj_now)
        arm <= 1'b0;
      if (rd_pend) begin
        sec_out <= {1'b0, recomp};
        sec_in  <= {1'b0, array_rdata.check};
        synd    <= sbe ? bitpos : 8'h00;
        ded_out <= recomp[6];
        ded_in  <= array_rdata.check[6];
      end
    end
  end

  // system outputs
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq          <= 1'b0;
      hard_trap    <= 1'b0;
      device_reset <= 1'b0;
    end else begin
      irq          <= sbe_flag & sbe_ie;
      hard_trap    <= dbe;
      device_reset <= dbe & ~handler;
    end
  end

  // read mux; unmapped offsets read zero
  logic [31:0] rd_word;
  always_comb begin
    rd_word = WORD_ZERO;
    unique case (haddr)
      OFF_FLAGS:   rd_word[SBE_BIT] = sbe_flag;
      OFF_INTERRUPT_ENABLE_REG_ZERO:    rd_word[SBE_BIT] = sbe_ie;
      OFF_STAT_LO: rd_word[15:0] = {sec_out, sec_in};
      OFF_STAT_HI: begin
        rd_word[7:0] = synd;
        rd_word[DED_OUT_BIT] = ded_out;
        rd_word[DED_IN_BIT] = ded_in;
      end
      OFF_TRAPS:   rd_word[DBE_BIT] = dbe_flag;
      OFF_TGT:     rd_word[ADDR_W-1:0] = target;
      OFF_FCTL_HI: rd_word[15:0] = {ptr2, ptr1};
      OFF_FCTL_LO: rd_word[ARM_BIT] = arm;
      OFF_TRAPCTL: rd_word[HANDLER_BIT] = handler;
      default:     rd_word = WORD_ZERO;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hrdata    <= WORD_ZERO;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      if (ap_valid && !hwrite) hrdata <= rd_word;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule : program_ram_ecc

//--- program_ram_ecc_properties.sv
/* port checker for the program-ram ecc block.
   assumes one clock mclk and the async low reset nrst. */
`timescale 1ns/1ps
module program_ram_ecc_properties
  import program_ram_ecc_pkg::*;
(
  input wire logic              mclk,
  input wire logic              nrst,
  input wire logic              core_req,
  input wire logic              core_we,
  input wire logic [ADDR_W-1:0] core_addr,
  input wire logic [DATA_W-1:0] core_wdata,
  input wire logic              core_rvalid,
  input wire logic [DATA_W-1:0] core_rdata,
  input wire array_req_t        array_req,
  input wire logic              array_req_valid,
  input wire array_word_t       array_rdata,
  input wire logic              hard_trap,
  input wire logic              device_reset
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  rd_latency_a: assert property (
    core_req && !core_we |-> ##2 core_rvalid)
    else $error("read answer missing");
  rd_array_a: assert property (core_req && !core_we |=> array_req_valid
    && !array_req.we && array_req.addr == $past(core_addr))
    else $error("read not sent to array");
  wr_store_a: assert property (core_req && core_we |=> array_req_valid
    && array_req.we) else $error("write not stored");
  wr_flip_a: assert property (core_req && core_we |=>
    $countones(array_req.data ^ $past(core_wdata)) <= 2)
    else $error("write data damaged");
  no_stray_a: assert property (
    array_req_valid |-> $past(core_req))
    else $error("array access without request");
  single_fix_a: assert property (core_rvalid && !hard_trap |->
    $countones(core_rdata ^ $past(array_rdata.data)) <= 1)
    else $error("uncorrected read");
  double_raw_a: assert property (core_rvalid && hard_trap |->
    $countones(core_rdata ^ $past(array_rdata.data)) inside {0, 2})
    else $error("double error data altered");
  trap_read_a: assert property (hard_trap |-> core_rvalid)
    else $error("trap without read");
  reset_trap_a: assert property (device_reset |-> hard_trap)
    else $error("device reset without trap");
endmodule : program_ram_ecc_properties

bind program_ram_ecc program_ram_ecc_properties chk_u (.mclk, .nrst, .core_req, .core_we,
  .core_addr, .core_wdata, .core_rvalid, .core_rdata, .array_req,
  .array_req_valid, .array_rdata, .hard_trap, .device_reset);

//--- program_ram_array_model.sv
/* program-ram array model, 16 words of data and check bits.
   assumes the block reads in the same cycle as array_req_valid. */
`timescale 1ns/1ps
module program_ram_array_model
  import program_ram_ecc_pkg::*;
(
  input  wire logic       mclk,
  input  wire array_req_t array_req,
  input  wire logic       array_req_valid,
  output array_word_t     array_rdata
);
  array_word_t mem [16];
  array_word_t last = '0;
  // idle bus shows inverted data so stale words never pass as fresh
  assign array_rdata = array_req_valid ? mem[array_req.addr[3:0]] : ~last;
  always @(posedge mclk) begin
    if (array_req_valid) begin
      last <= mem[array_req.addr[3:0]];
      if (array_req.we)
        mem[array_req.addr[3:0]] <= {array_req.data, array_req.check};
    end
  end
endmodule : program_ram_array_model

//--- program_ram_ecc_tb_top.sv
/* self-checking bench for the program-ram ecc block.
   assumes the array model answers in the request cycle. */
`timescale 1ns/1ps
module program_ram_ecc_tb_top
  import program_ram_ecc_pkg::*;
;
  localparam logic [47:0] D0 = 48'hA5A5_0F0F_1234;
  localparam logic [47:0] D1 = 48'h0123_4567_89AB;
  logic        mclk = 0, nrst = 0, hsel = 0, hwrite = 0, core_req = 0;
  logic        core_we = 0, hreadyout, hresp, core_rvalid, array_req_valid;
  logic        irq, hard_trap, device_reset;
  logic [7:0]  haddr = '0;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = '0, hrdata, q;
  logic [15:0] core_addr = '0;
  logic [47:0] core_wdata = '0, core_rdata, rd;
  array_req_t  array_req;
  array_word_t array_rdata;
  int          err_count = 0, checks = 0, traps = 0, resets = 0;

  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    if (hard_trap === 1'b1) traps <= traps + 1;
    if (device_reset === 1'b1) resets <= resets + 1;
  end

  program_ram_ecc dut_u (.mclk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .core_req,
    .core_we, .core_addr, .core_wdata, .core_rvalid, .core_rdata,
    .array_req, .array_req_valid, .array_rdata, .irq, .hard_trap,
    .device_reset);
  program_ram_array_model ram_u (.mclk, .array_req, .array_req_valid, .array_rdata);

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [47:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      chk(0, 1, "bus hang");
      conclude();
    end
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask : bus
  task automatic core(input logic w, input logic [15:0] a, input logic [47:0] d);
    int n;
    n = 0;
    core_req <= 1'b1;
    core_we <= w;
    core_addr <= a;
    core_wdata <= d;
    @(posedge mclk);
    core_req <= 1'b0;
    do begin
      @(posedge mclk);
      n++;
    end while (!w && core_rvalid !== 1'b1 && n < 8);
    if (!w && core_rvalid !== 1'b1) begin
      chk(0, 1, "core hang");
      conclude();
    end
    rd = core_rdata;
  endtask : core
  task automatic inject(input logic [15:0] ptrs, input logic key);
    bus(1, OFF_FCTL_HI, {16'h0, ptrs});
    if (key) begin
      bus(1, OFF_KEY, {24'h0, KEY_FIRST});
      bus(1, OFF_KEY, {24'h0, KEY_SECOND});
    end
    bus(1, OFF_FCTL_LO, 32'h1);
  endtask : inject

  initial begin
    repeat (20000) @(posedge mclk);
    chk(0, 1, "run timeout");
    conclude();
  end
  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    bus(0, OFF_FCTL_HI, 0);
    chk(48'(q), 48'(FCTL_HI_RST), "pointer reset");
    bus(0, 8'h40, 0);
    chk(48'(q), 48'h0, "unmapped read");
    core(1, 16'h1, D0);
    core(0, 16'h1, '0);
    chk(rd, D0, "clean data");
    bus(0, OFF_STAT_HI, 0);
    chk(48'(q[7:0]), 48'h0, "clean syndrome");
    chk(48'(q[DED_OUT_BIT]), 48'(q[DED_IN_BIT]), "detect bits");
    bus(0, OFF_STAT_LO, 0);
    chk(48'(q[15:8]), 48'(q[7:0]), "check fields");
    $display("test clean done");
    bus(1, OFF_INTERRUPT_ENABLE_REG_ZERO, 32'h1 << SBE_BIT);
    bus(1, OFF_TGT, 32'h2);
    inject({PTR_NONE, 8'h05}, 1'b1);
    core(1, 16'h3, D1);
    core(1, 16'h2, D1);
    core(0, 16'h3, '0);
    chk(rd, D1, "untargeted word");
    core(0, 16'h2, '0);
    chk(rd, D1, "corrected word");
    repeat (2) @(posedge mclk);
    chk(48'(irq), 48'h1, "irq raised");
    bus(0, OFF_FLAGS, 0);
    chk(48'(q[SBE_BIT]), 48'h1, "single flag");
    bus(0, OFF_STAT_HI, 0);
    chk(48'(q[7:0]), 48'h6, "syndrome position");
    bus(0, OFF_STAT_LO, 0);
    chk(48'(q[6:0]), 48'(ram_u.mem[2].check), "stored check");
    bus(1, OFF_FLAGS, 0);
    repeat (2) @(posedge mclk);
    chk(48'(irq), 48'h0, "irq cleared");
    $display("test write fault done");
    bus(1, OFF_TGT, 32'h1);
    for (int h = 0; h < 2; h++) begin
      bus(1, OFF_TRAPCTL, 32'(h));
      inject(16'h1002, 1'b1);
      core(0, 16'h1, '0);
      chk(rd, D0 ^ 48'h1_0004, "raw double");
      @(posedge mclk);
      chk(48'(traps), 48'(h + 1), "hard trap");
      chk(48'(resets), 48'h1, "device reset");
      bus(0, OFF_TRAPS, 0);
      chk(48'(q[DBE_BIT]), 48'h1, "trap flag");
      bus(1, OFF_TRAPS, 0);
      core(0, 16'h1, '0);
      chk(rd, D0, "array untouched");
    end
    $display("test read fault done");
    inject(16'hFF03, 1'b0);
    core(0, 16'h1, '0);
    bus(0, OFF_STAT_HI, 0);
    chk(48'(q[7:0]), 48'h0, "locked arm");
    $display("test lock done");
    conclude();
  end
endmodule : program_ram_ecc_tb_top
